/* File: src/sac_consts.svh */
/*
  Constants of the converter control block: bus offsets, field positions,
  reset values and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

`define SAC_CLK_NS 5
`define SAC_RESULT_W 12
`define SAC_ABORT_CODE 12'hfe0
`define SAC_RESULT_RST 12'h000
`define SAC_INIT_CONVS 3'h4

// timing in ns and derived cycle counts
`define SAC_CONV_TIME_NS 200
`define SAC_CONV_MAX_CYC (`SAC_CONV_TIME_NS / `SAC_CLK_NS)
`define SAC_CONV_DIV 8'h03
`define SAC_RESET_ABORT_NS 45
`define SAC_RESET_PHASE_NS 100
`define SAC_RESET_PHASE_CYC ((`SAC_RESET_PHASE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_PD_THRESH_NS 1000
`define SAC_PD_THRESH_CYC ((`SAC_PD_THRESH_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_PD_EXIT_NS 500
`define SAC_PD_EXIT_CYC (`SAC_PD_EXIT_NS / `SAC_CLK_NS)

// wishbone register map
`define SAC_ADDR_RESULT 8'h00
`define SAC_ADDR_STATUS 8'h04
`define SAC_ADDR_CTRL 8'h08

// status fields
`define SAC_ST_BUSY 0
`define SAC_ST_SAMPLING 1
`define SAC_ST_NAP 2
`define SAC_ST_RESET 3
`define SAC_ST_PWRDN 4
`define SAC_ST_WAKE 5
`define SAC_ST_VALID 6
`define SAC_ST_ABORTED 7
`define SAC_ST_INIT_LO 8

// control fields
`define SAC_CTRL_SOFT_NAP 0
`define SAC_CTRL_RST 1'h0

`endif

/* File: src/sac_pkg.sv */
/*
  Types of the converter control block.
  Assumes nothing beyond the constants header.
*/
package sac_pkg;
  typedef enum logic [2:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_CONVERT,
    SAC_RESET,
    SAC_PWRDN,
    SAC_WAKE
  } sac_state_t;
endpackage

/* File: src/sac_pin_sync.sv */
/*
  Two-flop synchroniser for one pin with edge outputs.
  Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module sac_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic rst_val_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic prev;

  // rst_val_i is a tie-off constant; it only picks the idle level of the pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= rst_val_i;
      level_o <= rst_val_i;
      prev <= rst_val_i;
    end else begin
      meta <= pin_i;
      level_o <= meta;
      prev <= level_o;
    end
  end

  assign rise_o = level_o & ~prev;
  assign fall_o = ~level_o & prev;
endmodule

/* File: src/sac_sar_engine.sv */
/*
  Successive-approximation engine: one trial bit per conversion clock
  enable, msb first. Assumes held_i stays stable during a conversion.
*/
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_sar_engine (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic step_i,
  input wire logic [11:0] held_i,
  output logic [11:0] code_o,
  output logic done_o
);
  logic [11:0] trial_bit;
  logic [11:0] next_code;

  // keep the trial bit only if the guess does not exceed the held level
  always_comb begin
    next_code = code_o | trial_bit;
    if (next_code > held_i) begin
      next_code = code_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      code_o <= `SAC_RESULT_RST;
      trial_bit <= 12'h000;
      done_o <= 1'b0;
    end else if (start_i) begin
      code_o <= 12'h000;
      trial_bit <= 12'h800;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (step_i && trial_bit != 12'h000) begin
        code_o <= next_code;
        trial_bit <= trial_bit >> 1;
        done_o <= trial_bit[0];
      end
    end
  end
endmodule

/* File: src/sac_control.sv */
/*
  Control and readout of a 12-bit successive-approximation converter with a
  parallel result bus, plus a classic Wishbone slave for status and control.
  Assumes the host pins are asynchronous to clk_i and that sample_level_i is
  the held analog level already quantised, stable while a conversion runs.
*/
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sac_consts.svh"
module sac_control
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // host pins
  input wire logic select_n_i,
  input wire logic convert_start_n_i,
  input wire logic read_n_i,
  input wire logic half_word_i,
  input wire logic nap_enable_n_i,
  input wire logic powerdown_reset_n_i,
  input wire logic [11:0] sample_level_i,
  output logic busy_o,
  output logic [11:0] result_o,
  output logic result_oe_o,
  output logic nap_o,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  // ==========================================================
  // pin sampling
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic cv_lvl;
  logic cv_rise;
  logic cv_fall;
  logic rd_lvl;
  logic hw_lvl;
  logic nap_lvl;
  logic pwd_lvl;

  // every pin goes through the same two-flop path so checks see one instant
  sac_pin_sync u_cs_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(select_n_i),
    .rst_val_i(1'b1),
    .level_o(cs_lvl),
    .rise_o(cs_rise),
    .fall_o(cs_fall)
  );

  sac_pin_sync u_cv_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(convert_start_n_i),
    .rst_val_i(1'b1),
    .level_o(cv_lvl),
    .rise_o(cv_rise),
    .fall_o(cv_fall)
  );

  sac_pin_sync u_rd_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(read_n_i),
    .rst_val_i(1'b1),
    .level_o(rd_lvl),
    .rise_o(),
    .fall_o()
  );

  sac_pin_sync u_hw_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(half_word_i),
    .rst_val_i(1'b0),
    .level_o(hw_lvl),
    .rise_o(),
    .fall_o()
  );

  sac_pin_sync u_nap_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(nap_enable_n_i),
    .rst_val_i(1'b1),
    .level_o(nap_lvl),
    .rise_o(),
    .fall_o()
  );

  sac_pin_sync u_pwd_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(powerdown_reset_n_i),
    .rst_val_i(1'b1),
    .level_o(pwd_lvl),
    .rise_o(),
    .fall_o()
  );

  // ==========================================================
  // conversion clock and engine
  sac_state_t state;
  sac_state_t next_state;
  logic [7:0] div_cnt;
  logic conv_step;
  logic conv_start;
  logic conv_abort;
  logic conv_done;
  logic [11:0] conv_code;
  logic [11:0] held_level;
  logic [11:0] result;
  logic aborted;
  logic soft_nap;
  logic [2:0] init_left;
  logic [15:0] phase_cnt;

  // 12 steps of 3 cycles plus the cycle that sees done: 37 cycles, inside the limit
  always_ff @(posedge clk_i) begin
    if (rst_i || state != SAC_CONVERT) begin
      div_cnt <= 8'h00;
    end else if (div_cnt == `SAC_CONV_DIV - 8'h01) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  assign conv_step = (state == SAC_CONVERT) && (div_cnt == `SAC_CONV_DIV - 8'h01);

  // sample is held at the moment sampling ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      held_level <= 12'h000;
    end else if (conv_start) begin
      held_level <= sample_level_i;
    end
  end

  sac_sar_engine u_sar (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(conv_start),
    .abort_i(conv_abort),
    .step_i(conv_step),
    .held_i(held_level),
    .code_o(conv_code),
    .done_o(conv_done)
  );

  // ==========================================================
  // sequencing
  always_comb begin
    next_state = state;
    conv_start = 1'b0;
    conv_abort = 1'b0;
    if (!pwd_lvl && state != SAC_RESET && state != SAC_PWRDN) begin
      next_state = SAC_RESET;
      conv_abort = 1'b1;
    end else begin
      unique case (state)
        SAC_IDLE: begin
          if (!cs_lvl && cv_rise && !busy_o) begin
            next_state = SAC_SAMPLE;
          end else if (cs_fall && cv_lvl && !busy_o) begin
            next_state = SAC_SAMPLE;
          end
        end
        SAC_SAMPLE: begin
          if ((cv_fall && !cs_lvl) || (cs_fall && !cv_lvl)) begin
            next_state = SAC_CONVERT;
            conv_start = 1'b1;
          end
        end
        SAC_CONVERT: begin
          if (cs_fall && cv_lvl) begin
            next_state = SAC_IDLE;
            conv_abort = 1'b1;
          end else if (conv_done) begin
            // sampling restarts here while busy is still high for one cycle
            if (!cs_lvl && cv_lvl) begin
              next_state = SAC_SAMPLE;
            end else begin
              next_state = SAC_IDLE;
            end
          end
        end
        SAC_RESET: begin
          if (pwd_lvl) begin
            next_state = SAC_IDLE;
          end else if (phase_cnt >= 16'(`SAC_PD_THRESH_CYC)) begin
            next_state = SAC_PWRDN;
          end
        end
        SAC_PWRDN: begin
          if (pwd_lvl) begin
            next_state = SAC_WAKE;
          end
        end
        SAC_WAKE: begin
          if (phase_cnt >= 16'(`SAC_PD_EXIT_CYC)) begin
            next_state = SAC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= SAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // time spent in the reset phase and in the wake-up delay
  always_ff @(posedge clk_i) begin
    if (rst_i || next_state != state) begin
      phase_cnt <= 16'h0000;
    end else if (phase_cnt != 16'hffff) begin
      phase_cnt <= phase_cnt + 16'h0001;
    end
  end

  // busy follows the conversion state one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (state == SAC_CONVERT);
    end
  end

  // ==========================================================
  // result and initialization count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= `SAC_RESULT_RST;
    end else if (state == SAC_RESET) begin
      result <= `SAC_ABORT_CODE;
    end else if (state == SAC_CONVERT && cs_fall && cv_lvl) begin
      result <= `SAC_ABORT_CODE;
    end else if (conv_done && next_state != SAC_RESET) begin
      result <= conv_code;
    end
  end

  // power-up and any reset both require four warm-up conversions
  always_ff @(posedge clk_i) begin
    if (rst_i || state == SAC_RESET || state == SAC_PWRDN) begin
      init_left <= `SAC_INIT_CONVS;
    end else if (conv_done && init_left != 3'h0) begin
      init_left <= init_left - 3'h1;
    end
  end

  // ==========================================================
  // nap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nap_o <= 1'b0;
    end else begin
      nap_o <= (next_state == SAC_IDLE) && (!nap_lvl || soft_nap)
               && (state == SAC_IDLE);
    end
  end

  // ==========================================================
  // parallel bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_oe_o <= 1'b0;
      result_o <= 12'h000;
    end else begin
      result_oe_o <= !cs_lvl && !rd_lvl;
      if (hw_lvl) begin
        result_o <= {result[3:0], 8'h00};
      end else begin
        result_o <= result;
      end
    end
  end

  // ==========================================================
  // wishbone slave
  logic wb_req;
  logic wb_wr;
  logic [31:0] status_word;

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr = wb_req && we_i;

  assign status_word = {21'h000000, init_left, aborted, (init_left == 3'h0),
                        (state == SAC_WAKE), (state == SAC_PWRDN),
                        (state == SAC_RESET), nap_o, (state == SAC_SAMPLE), busy_o};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (wb_req && !we_i) begin
      unique case (adr_i)
        `SAC_ADDR_RESULT: dat_o <= {20'h00000, result};
        `SAC_ADDR_STATUS: dat_o <= status_word;
        `SAC_ADDR_CTRL: dat_o <= {31'h00000000, soft_nap};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_nap <= `SAC_CTRL_RST;
    end else if (wb_wr && adr_i == `SAC_ADDR_CTRL && sel_i[0]) begin
      soft_nap <= dat_i[`SAC_CTRL_SOFT_NAP];
    end
  end

  // sticky abort flag: a new abort in the clearing cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aborted <= 1'b0;
    end else if (state == SAC_CONVERT && cs_fall && cv_lvl) begin
      aborted <= 1'b1;
    end else if (wb_wr && adr_i == `SAC_ADDR_STATUS && sel_i[0]
                 && dat_i[`SAC_ST_ABORTED]) begin
      aborted <= 1'b0;
    end
  end
endmodule

/* File: testbench/sac_control_chk.sv */
/*
  Port checker of the converter control block.
  Assumes it is bound to the design top by the bench.
*/
`timescale 1ns/1ps
module sac_control_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic select_n_i,
  input wire logic convert_start_n_i,
  input wire logic read_n_i,
  input wire logic half_word_i,
  input wire logic powerdown_reset_n_i,
  input wire logic busy_o,
  input wire logic [11:0] result_o,
  input wire logic result_oe_o,
  input wire logic nap_o,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o
);
  // ==========================================
  // helpers
  logic [7:0] busy_cnt;
  logic [7:0] pd_cnt;
  logic [7:0] both_low;
  always_ff @(posedge clk_i) begin
    if (rst_i || !busy_o) busy_cnt <= 8'h00;
    else if (busy_cnt != 8'hff) busy_cnt <= busy_cnt + 8'h01;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || powerdown_reset_n_i) pd_cnt <= 8'h00;
    else if (pd_cnt != 8'hff) pd_cnt <= pd_cnt + 8'h01;
  end
  // pins pass a two-flop sync, so the cause lies a few cycles back
  always_ff @(posedge clk_i) begin
    both_low <= {both_low[6:0], !select_n_i && !convert_start_n_i};
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_busy_bound: assert property (busy_cnt <= 8'h28)
    else $error("busy longer than 40 cycles");
  a_busy_cause: assert property ($rose(busy_o) |-> |both_low)
    else $error("busy rose without start condition");
  a_busy_hold: assert property ($rose(busy_o) |=> busy_o [*8])
    else $error("busy dropped early");
  a_oe_strobes: assert property (result_oe_o |-> !$past(select_n_i, 3) && !$past(read_n_i, 3))
    else $error("bus driven without select and read");
  a_half_low: assert property (result_oe_o && $past(half_word_i, 3) && $past(half_word_i, 4)
    |-> result_o[7:0] == 8'h00)
    else $error("half word low bits not zero");
  a_reset_code: assert property (pd_cnt >= 8'h0c && result_oe_o && !$past(half_word_i, 3)
    && !$past(half_word_i, 4) |-> result_o == 12'hfe0)
    else $error("reset code missing");
  // 45 ns is nine cycles after the pin edge, when pd_cnt reads eight
  a_reset_abort: assert property (pd_cnt >= 8'h08 |-> !busy_o)
    else $error("conversion not aborted by reset pin");
  a_nap_idle: assert property (nap_o |-> !busy_o)
    else $error("nap while busy");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  c_conv: cover property ($fell(busy_o));
  c_nap: cover property ($rose(nap_o));
  c_pwrdn: cover property (pd_cnt == 8'hc8);
endmodule

/* File: testbench/sac_host_model.sv */
/*
  Host side of the parallel pins.
  Assumes the bench calls its tasks; pins change just after a rising edge.
*/
`timescale 1ns/1ps
module sac_host_model (
  input wire logic clk_i,
  output logic select_n_o,
  output logic convert_start_n_o,
  output logic read_n_o,
  output logic half_word_o,
  output logic nap_enable_n_o,
  output logic powerdown_reset_n_o
);
  // acquisition length keeps back-to-back pacing legal
  localparam int ACQ = 6;
  logic [5:0] pins = 6'h37;
  assign {powerdown_reset_n_o, nap_enable_n_o, half_word_o} = pins[5:3];
  assign {read_n_o, convert_start_n_o, select_n_o} = pins[2:0];
  task automatic set(input int pin, input logic v, input int hold);
    @(posedge clk_i);
    pins[pin] <= v;
    repeat (hold) @(posedge clk_i);
  endtask
  task automatic convert(input int mode, input int napped);
    int acq;
    acq = ACQ + (napped != 0 ? 12 : 0);
    if (mode == 0) begin
      set(1, 1'b0, 4);
      set(0, 1'b0, 4);
      set(1, 1'b1, acq);
      set(1, 1'b0, 0);
    end else begin
      set(0, 1'b1, 4);
      set(1, 1'b1, 4);
      set(0, 1'b0, acq);
      set(0, 1'b1, 4);
      set(1, 1'b0, 4);
      set(0, 1'b0, 0);
    end
  endtask
endmodule

/* File: testbench/test_sac_control.sv */
/*
  Self-checking bench of the converter control block.
  Assumes the host model drives the pins and Wishbone reaches the registers.
*/
`timescale 1ns/1ps
module test_sac_control;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, lfsr = 32'h7110a7ab;
  logic [11:0] sample_level_i = 12'h000, result_o, lvl;
  logic select_n_i, convert_start_n_i, read_n_i, half_word_i, nap_enable_n_i;
  logic powerdown_reset_n_i, busy_o, result_oe_o, nap_o, ack_o;
  int errors = 0, n_compared = 0, cycles = 0;
  logic [11:0] exp_q[$];
  sac_control i_dut (.clk_i, .rst_i, .select_n_i, .convert_start_n_i, .read_n_i,
    .half_word_i, .nap_enable_n_i, .powerdown_reset_n_i, .sample_level_i, .busy_o,
    .result_o, .result_oe_o, .nap_o, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o);
  sac_host_model i_host (.clk_i, .select_n_o(select_n_i),
    .convert_start_n_o(convert_start_n_i), .read_n_o(read_n_i),
    .half_word_o(half_word_i), .nap_enable_n_o(nap_enable_n_i),
    .powerdown_reset_n_o(powerdown_reset_n_i));
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      report_and_stop();
    end
  end
  // ==========================================
  // shared tasks
  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 4'hf, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    check(32'(ack_o), 32'h1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic wait_busy(input logic lv, input int lim);
    int n;
    n = 0;
    while (busy_o !== lv && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(32'(busy_o), 32'(lv));
  endtask
  task automatic conv(input int mode, input int napped);
    lfsr = next_rand(lfsr);
    lvl = lfsr[11:0];
    sample_level_i <= lvl;
    exp_q.push_back(lvl);
    i_host.convert(mode, napped);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 50);
  endtask
  task automatic read_res();
    lvl = exp_q.pop_front();
    i_host.set(2, 1'b0, 6);
    check(32'(result_oe_o), 32'h1);
    check(32'(result_o), 32'(lvl));
    i_host.set(3, 1'b1, 6);
    check(32'(result_o), 32'({lvl[3:0], 8'h00}));
    i_host.set(3, 1'b0, 0);
    i_host.set(2, 1'b1, 6);
    check(32'(result_oe_o), 32'h0);
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h1);
    check(32'(nap_o), 32'h1);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[10:6]), 32'h10);
    $display("registers done");
    for (int i = 0; i < 4; i++) conv(i % 2, 0);
    exp_q.delete();
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[10:6]), 32'h01);
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      conv(i % 2, 0);
      // full scale and zero as boundary codes come in the first two rounds
      if (i < 2) begin
        exp_q.delete(0);
        lvl = (i == 0) ? 12'hfff : 12'h000;
        sample_level_i <= lvl;
        exp_q.push_back(lvl);
        i_host.convert(i % 2, 0);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 50);
      end
      read_res();
    end
    $display("conversions done");
    conv(0, 0);
    i_host.convert(0, 0);
    exp_q.push_back(lvl);
    wait_busy(1'b1, 10);
    i_host.set(1, 1'b1, 4);
    wait_busy(1'b0, 50);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[1]), 32'h1);
    i_host.set(1, 1'b0, 0);
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 50);
    exp_q.delete(0);
    read_res();
    $display("back to back done");
    i_host.convert(0, 0);
    wait_busy(1'b1, 10);
    i_host.set(1, 1'b1, 4);
    i_host.set(0, 1'b1, 4);
    i_host.set(0, 1'b0, 0);
    wait_busy(1'b0, 8);
    exp_q.push_back(12'hfe0);
    read_res();
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[7]), 32'h1);
    wb(1'b1, 8'h04, 32'h80);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[7]), 32'h0);
    $display("abort done");
    i_host.set(4, 1'b0, 4);
    conv(0, 0);
    repeat (4) @(posedge clk_i);
    check(32'(nap_o), 32'h1);
    conv(0, 1);
    i_host.set(4, 1'b1, 6);
    check(32'(nap_o), 32'h0);
    exp_q.delete(0);
    read_res();
    $display("nap done");
    i_host.convert(0, 0);
    wait_busy(1'b1, 10);
    repeat (8) @(posedge clk_i);
    i_host.set(5, 1'b0, 4);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[3]), 32'h1);
    i_host.set(2, 1'b0, 6);
    check(32'(result_o), 32'hfe0);
    check(32'(busy_o), 32'h0);
    repeat (220) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[4]), 32'h1);
    i_host.set(2, 1'b1, 0);
    i_host.set(5, 1'b1, 110);
    wb(1'b0, 8'h04, 32'h0);
    check(32'(rd[10:8]), 32'h4);
    check(32'(rd[4]), 32'h0);
    $display("powerdown done");
    report_and_stop();
  end
endmodule
bind sac_control sac_control_chk i_chk (.clk_i, .rst_i, .select_n_i, .convert_start_n_i,
  .read_n_i, .half_word_i, .powerdown_reset_n_i, .busy_o, .result_o, .result_oe_o,
  .nap_o, .cyc_i, .stb_i, .ack_o);
